/* core/pmwp_pkg.sv */
package pmwp_pkg;
    // Command codes handled by this block
    localparam logic [7:0] CMD_CHANNEL_SELECT = 8'h00;
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
    localparam logic [7:0] CMD_PAGE_PLUS_WRITE = 8'h05;
    localparam logic [7:0] CMD_PAGE_PLUS_READ = 8'h06;
    localparam logic [7:0] CMD_WRITE_LOCK_LEVEL = 8'h10;
    localparam logic [7:0] CMD_VOUT_COMMAND = 8'h21;
    localparam logic [7:0] CMD_BUS_TARGET_ID = 8'he6;
    localparam logic [7:0] CMD_SHARED_RAIL_TARGET_ID = 8'hfa;
    // Reset values
    localparam logic [7:0] RST_CHANNEL_SELECT = 8'h00;
    localparam logic [7:0] RST_WRITE_LOCK_LEVEL = 8'h00;
    localparam logic [7:0] RST_BUS_TARGET_ID = 8'h4f;
    localparam logic [7:0] RST_SHARED_RAIL_TARGET_ID = 8'h80;
    // Channel select values
    localparam logic [7:0] PAGE_CH0 = 8'h00;
    localparam logic [7:0] PAGE_CH1 = 8'h01;
    localparam logic [7:0] PAGE_ALL = 8'hff;
    // Address values
    localparam logic [7:0] ADDR_DISABLED = 8'h80;
    localparam logic [6:0] ADDR_GLOBAL_A = 7'h5a;
    localparam logic [6:0] ADDR_GLOBAL_B = 7'h5b;
    // Write lock level bit positions
    localparam int WLL_BIT_ALL = 7;
    localparam int WLL_BIT_OPS = 6;
    localparam int WLL_BIT_CFG = 5;
    // Channel masks
    localparam logic [1:0] MASK_NONE = 2'h0;
    localparam logic [1:0] MASK_CH0 = 2'h1;
    localparam logic [1:0] MASK_CH1 = 2'h2;
    localparam logic [1:0] MASK_BOTH = 2'h3;
endpackage

/* core/pmwp_ctl_if.sv */
`timescale 1ns/100ps
interface pmwp_ctl_if;
    // Write permission check
    logic [7:0] wll;
    logic wp_pin;
    logic [7:0] code;
    logic w1c;
    logic allow;
    // Address match
    logic [7:0] dev_id;
    logic [7:0] rail_id [2];
    logic [3:0] strap_low;
    logic [2:0] strap_high;
    logic low_open;
    logic high_open;
    logic [6:0] probe;
    logic hit_dev;
    logic hit_global;
    logic [1:0] hit_rail;
    logic [6:0] eff_addr;
    modport gate (input wll, wp_pin, code, w1c, output allow);
    modport gate_user (output wll, wp_pin, code, w1c, input allow);
    modport dec (input dev_id, rail_id, strap_low, strap_high, low_open, high_open, probe,
                 output hit_dev, hit_global, hit_rail, eff_addr);
    modport dec_user (output dev_id, rail_id, strap_low, strap_high, low_open, high_open,
                      probe, input hit_dev, hit_global, hit_rail, eff_addr);
endinterface

/* core/pmwp_gate.sv */
`timescale 1ns/100ps
module pmwp_gate #(
    parameter logic [7:0] CODE_CLEAR_FAULTS = 8'h03,
    parameter logic [7:0] CODE_STORE_USER_ALL = 8'h15,
    parameter logic [7:0] CODE_EEPROM_UNLOCK = 8'hfe,
    parameter logic [7:0] CODE_PEAK_CLEAR = 8'hfc
) (
    pmwp_ctl_if.gate g
);
    // Commands writable under the strictest level
    function automatic logic in_base_set(input logic [7:0] c);
        in_base_set = (c == pmwp_pkg::CMD_WRITE_LOCK_LEVEL) ||
                      (c == pmwp_pkg::CMD_CHANNEL_SELECT) ||
                      (c == CODE_EEPROM_UNLOCK) || (c == CODE_STORE_USER_ALL);
    endfunction

    // Operational commands kept open at the middle level and by the pin
    function automatic logic in_ops_set(input logic [7:0] c);
        in_ops_set = (c == CODE_PEAK_CLEAR) || (c == pmwp_pkg::CMD_OPERATION) ||
                     (c == CODE_CLEAR_FAULTS);
    endfunction

    // Pin wins over level; highest level bit wins; reserved bits are ignored
    always_comb begin
        if (g.wp_pin) begin
            g.allow = g.w1c || in_ops_set(g.code) || (g.code == CODE_EEPROM_UNLOCK) ||
                      (g.code == pmwp_pkg::CMD_CHANNEL_SELECT);
        end else if (g.wll[pmwp_pkg::WLL_BIT_ALL]) begin
            g.allow = in_base_set(g.code);
        end else if (g.wll[pmwp_pkg::WLL_BIT_OPS]) begin
            g.allow = g.w1c || in_base_set(g.code) || in_ops_set(g.code);
        end else if (g.wll[pmwp_pkg::WLL_BIT_CFG]) begin
            g.allow = g.w1c || in_base_set(g.code) || in_ops_set(g.code) ||
                      (g.code == pmwp_pkg::CMD_ON_OFF_CONFIG) ||
                      (g.code == pmwp_pkg::CMD_VOUT_COMMAND);
        end else begin
            g.allow = 1'b1;
        end
    end
endmodule

/* core/pmwp_addr_dec.sv */
`timescale 1ns/100ps
module pmwp_addr_dec (
    pmwp_ctl_if.dec d
);
    logic [6:0] eff;

    // Straps give the address unless a strap pin is left open
    always_comb begin
        eff[6:4] = d.high_open ? d.dev_id[6:4] : d.strap_high;
        eff[3:0] = d.low_open ? d.dev_id[3:0] : d.strap_low;
    end

    assign d.eff_addr = eff;
    assign d.hit_dev = (d.dev_id != pmwp_pkg::ADDR_DISABLED) && (d.probe == eff);
    assign d.hit_global = (d.probe == pmwp_pkg::ADDR_GLOBAL_A) ||
                          (d.probe == pmwp_pkg::ADDR_GLOBAL_B);

    // Each channel answers its own shared rail address
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_rail
            assign d.hit_rail[ch] = (d.rail_id[ch] != pmwp_pkg::ADDR_DISABLED) &&
                                    (d.probe == d.rail_id[ch][6:0]);
        end
    endgenerate
endmodule

/* core/pmwp_top.sv */
`timescale 1ns/100ps
module pmwp_top #(
    parameter logic [7:0] CODE_CLEAR_FAULTS = 8'h03,
    parameter logic [7:0] CODE_STORE_USER_ALL = 8'h15,
    parameter logic [7:0] CODE_EEPROM_UNLOCK = 8'hfe,
    parameter logic [7:0] CODE_PEAK_CLEAR = 8'hfc
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic i_wp_pin,
    input wire logic [3:0] i_addr_strap_low,
    input wire logic i_addr_strap_low_open,
    input wire logic [2:0] i_addr_strap_high,
    input wire logic i_addr_strap_high_open,
    input wire logic i_addr_valid,
    input wire logic [6:0] i_addr,
    input wire logic i_rail_rd_mismatch,
    input wire logic i_cmd_valid,
    input wire logic i_cmd_write,
    input wire logic [7:0] i_cmd_code,
    input wire logic [7:0] i_cmd_data,
    input wire logic i_cmd_paged,
    input wire logic i_cmd_w1c,
    input wire logic [7:0] i_pp_page,
    input wire logic [7:0] i_pp_code,
    output logic o_addr_ack,
    output logic o_addr_global,
    output logic [1:0] o_addr_rail_mask,
    output logic [6:0] o_eff_addr,
    output logic o_cmd_ack,
    output logic o_cmd_nack,
    output logic o_xfer_valid,
    output logic o_xfer_write,
    output logic o_xfer_own,
    output logic [7:0] o_xfer_code,
    output logic [7:0] o_xfer_data,
    output logic [1:0] o_xfer_ch_mask,
    output logic [7:0] o_rd_data,
    output logic o_cml_data_fault,
    output logic o_cml_comm_fault,
    output logic [7:0] o_channel_select,
    output logic [7:0] o_write_lock_level
);
    pmwp_ctl_if ctl ();

    // Pin synchronisers: stage one feeds only stage two
    logic [9:0] sync1_ff;
    logic [9:0] sync2_ff;
    logic [9:0] nxt_sync1;
    logic [9:0] nxt_sync2;

    // Register file and registered outputs
    logic [7:0] channel_select_ff;
    logic [7:0] write_lock_level_ff;
    logic [7:0] bus_target_id_ff;
    logic [7:0] shared_rail_target_id_ff [2];
    logic xfer_valid_ff;
    logic xfer_write_ff;
    logic xfer_own_ff;
    logic [7:0] xfer_code_ff;
    logic [7:0] xfer_data_ff;
    logic [1:0] xfer_ch_mask_ff;
    logic [7:0] rd_data_ff;
    logic data_fault_ff;
    logic comm_fault_ff;
    logic [7:0] nxt_channel_select;
    logic [7:0] nxt_write_lock_level;
    logic [7:0] nxt_bus_target_id;
    logic [7:0] nxt_shared_rail_target_id [2];
    logic nxt_xfer_valid;
    logic nxt_xfer_write;
    logic nxt_xfer_own;
    logic [7:0] nxt_xfer_code;
    logic [7:0] nxt_xfer_data;
    logic [1:0] nxt_xfer_ch_mask;
    logic [7:0] nxt_rd_data;
    logic nxt_data_fault;
    logic nxt_comm_fault;

    // Decode of the current request
    logic is_pp;
    logic nested;
    logic is_wr;
    logic [7:0] code;
    logic paged;
    logic own_reg;
    logic [7:0] page;
    logic [1:0] ch_mask;
    logic page_ok;
    logic pp_page_wr;
    logic accept;
    logic refuse;

    always_comb begin
        nxt_sync1 = {i_wp_pin, i_addr_strap_low_open, i_addr_strap_high_open,
                     i_addr_strap_high, i_addr_strap_low};
        nxt_sync2 = sync1_ff;
    end

    // Outer code selects plain or combined page packet handling
    always_comb begin
        is_pp = (i_cmd_code == pmwp_pkg::CMD_PAGE_PLUS_WRITE) ||
                (i_cmd_code == pmwp_pkg::CMD_PAGE_PLUS_READ);
        code = is_pp ? i_pp_code : i_cmd_code;
        nested = is_pp && ((i_pp_code == pmwp_pkg::CMD_PAGE_PLUS_WRITE) ||
                           (i_pp_code == pmwp_pkg::CMD_PAGE_PLUS_READ));
        is_wr = is_pp ? (i_cmd_code == pmwp_pkg::CMD_PAGE_PLUS_WRITE) : i_cmd_write;
        own_reg = (code == pmwp_pkg::CMD_CHANNEL_SELECT) ||
                  (code == pmwp_pkg::CMD_WRITE_LOCK_LEVEL) ||
                  (code == pmwp_pkg::CMD_BUS_TARGET_ID) ||
                  (code == pmwp_pkg::CMD_SHARED_RAIL_TARGET_ID);
        paged = (code == pmwp_pkg::CMD_SHARED_RAIL_TARGET_ID) || (!own_reg && i_cmd_paged);
        page = is_pp ? i_pp_page : channel_select_ff;
        page_ok = 1'b1;
        ch_mask = pmwp_pkg::MASK_NONE;
        if (paged) begin
            if (page == pmwp_pkg::PAGE_CH0) begin
                ch_mask = pmwp_pkg::MASK_CH0;
            end else if (page == pmwp_pkg::PAGE_CH1) begin
                ch_mask = pmwp_pkg::MASK_CH1;
            end else if (page == pmwp_pkg::PAGE_ALL) begin
                ch_mask = is_wr ? pmwp_pkg::MASK_BOTH : pmwp_pkg::MASK_CH0;
            end else begin
                page_ok = 1'b0;
            end
        end
        pp_page_wr = is_pp && is_wr && (code == pmwp_pkg::CMD_CHANNEL_SELECT);
        accept = i_cmd_valid && !nested && page_ok && !pp_page_wr &&
                 (!is_wr || ctl.allow);
        refuse = i_cmd_valid && !accept;
    end

    // Write permission inputs
    always_comb begin
        ctl.wll = write_lock_level_ff;
        ctl.wp_pin = sync2_ff[9];
        ctl.code = code;
        ctl.w1c = i_cmd_w1c;
    end

    // Address decode inputs
    always_comb begin
        ctl.dev_id = bus_target_id_ff;
        ctl.rail_id[0] = shared_rail_target_id_ff[0];
        ctl.rail_id[1] = shared_rail_target_id_ff[1];
        ctl.strap_low = sync2_ff[3:0];
        ctl.strap_high = sync2_ff[6:4];
        ctl.high_open = sync2_ff[7];
        ctl.low_open = sync2_ff[8];
        ctl.probe = i_addr;
    end

    pmwp_gate #(
        .CODE_CLEAR_FAULTS(CODE_CLEAR_FAULTS),
        .CODE_STORE_USER_ALL(CODE_STORE_USER_ALL),
        .CODE_EEPROM_UNLOCK(CODE_EEPROM_UNLOCK),
        .CODE_PEAK_CLEAR(CODE_PEAK_CLEAR)
    ) pmwp_gate_inst (
        .g(ctl.gate)
    );

    pmwp_addr_dec pmwp_addr_dec_inst (
        .d(ctl.dec)
    );

    // Handshake answers, same cycle as the request
    always_comb begin
        o_cmd_ack = i_clk_en && accept;
        o_cmd_nack = i_clk_en && refuse;
        o_addr_global = i_clk_en && i_addr_valid && ctl.hit_global;
        o_addr_rail_mask = (i_clk_en && i_addr_valid) ? ctl.hit_rail : pmwp_pkg::MASK_NONE;
        o_addr_ack = i_clk_en && i_addr_valid && (ctl.hit_dev || ctl.hit_global ||
                     (ctl.hit_rail != pmwp_pkg::MASK_NONE));
    end

    // Register updates, read data and transfer hand-off
    always_comb begin
        nxt_channel_select = channel_select_ff;
        nxt_write_lock_level = write_lock_level_ff;
        nxt_bus_target_id = bus_target_id_ff;
        nxt_shared_rail_target_id = shared_rail_target_id_ff;
        nxt_xfer_valid = accept;
        nxt_xfer_write = xfer_write_ff;
        nxt_xfer_own = xfer_own_ff;
        nxt_xfer_code = xfer_code_ff;
        nxt_xfer_data = xfer_data_ff;
        nxt_xfer_ch_mask = xfer_ch_mask_ff;
        nxt_rd_data = rd_data_ff;
        nxt_data_fault = refuse;
        nxt_comm_fault = i_rail_rd_mismatch;
        if (accept) begin
            nxt_xfer_write = is_wr;
            nxt_xfer_own = own_reg;
            nxt_xfer_code = code;
            nxt_xfer_data = i_cmd_data;
            nxt_xfer_ch_mask = ch_mask;
            if (is_wr) begin
                if (code == pmwp_pkg::CMD_CHANNEL_SELECT) begin
                    nxt_channel_select = i_cmd_data;
                end else if (code == pmwp_pkg::CMD_WRITE_LOCK_LEVEL) begin
                    nxt_write_lock_level = i_cmd_data;
                end else if (code == pmwp_pkg::CMD_BUS_TARGET_ID) begin
                    nxt_bus_target_id = i_cmd_data;
                end else if (code == pmwp_pkg::CMD_SHARED_RAIL_TARGET_ID) begin
                    for (int ch = 0; ch < 2; ch++) begin
                        if (ch_mask[ch]) begin
                            nxt_shared_rail_target_id[ch] = i_cmd_data;
                        end
                    end
                end
            end else begin
                if (code == pmwp_pkg::CMD_CHANNEL_SELECT) begin
                    nxt_rd_data = channel_select_ff;
                end else if (code == pmwp_pkg::CMD_WRITE_LOCK_LEVEL) begin
                    nxt_rd_data = write_lock_level_ff;
                end else if (code == pmwp_pkg::CMD_BUS_TARGET_ID) begin
                    nxt_rd_data = bus_target_id_ff;
                end else if (code == pmwp_pkg::CMD_SHARED_RAIL_TARGET_ID) begin
                    nxt_rd_data = ch_mask[1] ? shared_rail_target_id_ff[1] :
                                  shared_rail_target_id_ff[0];
                end else begin
                    nxt_rd_data = rd_data_ff;
                end
            end
        end
    end

    // State registers, frozen while the clock enable is low
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            channel_select_ff <= pmwp_pkg::RST_CHANNEL_SELECT;
            write_lock_level_ff <= pmwp_pkg::RST_WRITE_LOCK_LEVEL;
            bus_target_id_ff <= pmwp_pkg::RST_BUS_TARGET_ID;
            shared_rail_target_id_ff[0] <= pmwp_pkg::RST_SHARED_RAIL_TARGET_ID;
            shared_rail_target_id_ff[1] <= pmwp_pkg::RST_SHARED_RAIL_TARGET_ID;
            xfer_valid_ff <= 1'b0;
            xfer_write_ff <= 1'b0;
            xfer_own_ff <= 1'b0;
            xfer_code_ff <= '0;
            xfer_data_ff <= '0;
            xfer_ch_mask_ff <= pmwp_pkg::MASK_NONE;
            rd_data_ff <= '0;
            data_fault_ff <= 1'b0;
            comm_fault_ff <= 1'b0;
        end else if (i_clk_en) begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            channel_select_ff <= nxt_channel_select;
            write_lock_level_ff <= nxt_write_lock_level;
            bus_target_id_ff <= nxt_bus_target_id;
            shared_rail_target_id_ff <= nxt_shared_rail_target_id;
            xfer_valid_ff <= nxt_xfer_valid;
            xfer_write_ff <= nxt_xfer_write;
            xfer_own_ff <= nxt_xfer_own;
            xfer_code_ff <= nxt_xfer_code;
            xfer_data_ff <= nxt_xfer_data;
            xfer_ch_mask_ff <= nxt_xfer_ch_mask;
            rd_data_ff <= nxt_rd_data;
            data_fault_ff <= nxt_data_fault;
            comm_fault_ff <= nxt_comm_fault;
        end
    end

    // Registered outputs; one-cycle pulses drop while the enable is low
    always_comb begin
        o_xfer_valid = xfer_valid_ff && i_clk_en;
        o_xfer_write = xfer_write_ff;
        o_xfer_own = xfer_own_ff;
        o_xfer_code = xfer_code_ff;
        o_xfer_data = xfer_data_ff;
        o_xfer_ch_mask = xfer_ch_mask_ff;
        o_rd_data = rd_data_ff;
        o_cml_data_fault = data_fault_ff && i_clk_en;
        o_cml_comm_fault = comm_fault_ff && i_clk_en;
        o_channel_select = channel_select_ff;
        o_write_lock_level = write_lock_level_ff;
        o_eff_addr = ctl.eff_addr;
    end
endmodule

/* sim/pmwp_chk.sv */
`timescale 1ns/100ps
// Protocol checker on the command and address ports
module pmwp_chk (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic i_wp_pin,
    input wire logic i_addr_valid,
    input wire logic [6:0] i_addr,
    input wire logic i_rail_rd_mismatch,
    input wire logic i_cmd_valid,
    input wire logic i_cmd_write,
    input wire logic [7:0] i_cmd_code,
    input wire logic i_cmd_paged,
    input wire logic [7:0] i_pp_page,
    input wire logic o_addr_ack,
    input wire logic o_addr_global,
    input wire logic o_cmd_ack,
    input wire logic o_cmd_nack,
    input wire logic [1:0] o_xfer_ch_mask,
    input wire logic o_cml_data_fault,
    input wire logic o_cml_comm_fault,
    input wire logic [7:0] o_channel_select,
    input wire logic [7:0] o_write_lock_level
);
    logic [2:0] wp_hist_ff;
    logic [2:0] nxt_wp_hist;
    logic req;
    logic pp;
    // Pin history over enabled edges, so the synchroniser has settled
    always_comb begin
        nxt_wp_hist = wp_hist_ff;
        if (i_clk_en) begin
            nxt_wp_hist = {wp_hist_ff[1:0], i_wp_pin};
        end
    end
    always_ff @(posedge i_clk) begin
        wp_hist_ff <= i_reset_n ? nxt_wp_hist : 3'h0;
    end
    // Request qualifiers
    assign req = i_cmd_valid && i_clk_en;
    assign pp = i_cmd_code == 8'h05 || i_cmd_code == 8'h06;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    AST_ONE_ANSWER: assert property (req |-> o_cmd_ack ^ o_cmd_nack)
        else $error("ack and nack disagree");
    AST_NACK_FAULT: assert property (o_cmd_nack ##1 i_clk_en |-> o_cml_data_fault)
        else $error("refusal without data fault");
    AST_COMM_FAULT: assert property (i_rail_rd_mismatch && i_clk_en ##1 i_clk_en
        |-> o_cml_comm_fault)
        else $error("rail contention not flagged");
    AST_PP_KEEPS_PAGE: assert property (req && pp |=> $stable(o_channel_select))
        else $error("combined packet moved channel select");
    AST_GLOBAL: assert property (i_addr_valid && i_clk_en && i_addr[6:1] == 6'h2d
        |-> o_addr_ack && o_addr_global)
        else $error("global address not answered");
    AST_OPEN_LEVEL: assert property (req && i_cmd_write && !pp && !i_cmd_paged
        && i_cmd_code != 8'hfa && o_write_lock_level == 8'h00 && wp_hist_ff == 3'h0
        |-> o_cmd_ack)
        else $error("write refused while unlocked");
    AST_FULL_LOCK: assert property (req && i_cmd_write && i_cmd_code == 8'h01
        && o_write_lock_level[7] && wp_hist_ff == 3'h0 |-> o_cmd_nack)
        else $error("operation write passed full lock");
    AST_PIN_LOCK: assert property (req && i_cmd_write && i_cmd_code == 8'h10
        && wp_hist_ff == 3'h7 |-> o_cmd_nack)
        else $error("lock level write passed protect pin");
    AST_PAGE_ALL_READ: assert property (req && i_cmd_code == 8'h06 && i_pp_page == 8'hff
        && i_cmd_paged && o_cmd_ack ##1 i_clk_en |-> o_xfer_ch_mask == 2'h1)
        else $error("all-page read not on channel 0");
    AST_REFUSED_KEEPS: assert property (o_cmd_nack |=> $stable(o_write_lock_level))
        else $error("refused write changed lock level");
endmodule

/* sim/pmwp_host.sv */
`timescale 1ns/100ps
// Bus host model issuing decoded commands and address probes
module pmwp_host (
    input wire logic i_clk,
    input wire logic i_cmd_ack,
    input wire logic i_addr_ack,
    input wire logic i_addr_global,
    input wire logic [1:0] i_rail_mask,
    output logic o_cmd_valid,
    output logic o_cmd_write,
    output logic o_cmd_w1c,
    output logic o_cmd_paged,
    output logic [7:0] o_cmd_code,
    output logic [7:0] o_cmd_data,
    output logic [7:0] o_pp_page,
    output logic [7:0] o_pp_code,
    output logic o_addr_valid,
    output logic [6:0] o_addr
);
    // Idle at time zero
    initial begin
        {o_cmd_valid, o_cmd_write, o_cmd_w1c, o_cmd_paged, o_addr_valid} = 5'h00;
        {o_cmd_code, o_cmd_data, o_pp_page, o_pp_code, o_addr} = 39'h0;
    end
    // One packet held across its taking edge; released lines toggle
    task automatic cmd(input logic w, input logic c1, input logic [7:0] c, input logic [7:0] d,
                       input logic pg, input logic [7:0] pa, input logic [7:0] pc,
                       output logic ack);
        @(posedge i_clk);
        #1;
        {o_cmd_write, o_cmd_w1c, o_cmd_paged, o_cmd_code, o_cmd_data} = {w, c1, pg, c, d};
        {o_pp_page, o_pp_code, o_cmd_valid} = {pa, pc, 1'b1};
        #2 ack = i_cmd_ack;
        @(posedge i_clk);
        #1;
        o_cmd_valid = 1'b0;
        o_cmd_code = ~c;
        o_cmd_data = ~d;
    endtask
    // One address probe, answer taken before the edge
    task automatic probe(input logic [6:0] ad, output logic ack, output logic gl,
                         output logic [1:0] mk);
        @(posedge i_clk);
        #1;
        {o_addr_valid, o_addr} = {1'b1, ad};
        #2 {ack, gl, mk} = {i_addr_ack, i_addr_global, i_rail_mask};
        @(posedge i_clk);
        #1;
        {o_addr_valid, o_addr} = {1'b0, ~ad};
    endtask
endmodule

/* sim/pmbus_page_addr_write_protect_tb_top.sv */
`timescale 1ns/100ps
module pmbus_page_addr_write_protect_tb_top;
    logic i_clk, i_reset_n, i_clk_en, i_wp_pin, i_addr_valid, i_rail_rd_mismatch, i_cmd_w1c;
    logic i_cmd_valid, i_cmd_write, i_cmd_paged, i_addr_strap_low_open, i_addr_strap_high_open;
    logic [3:0] i_addr_strap_low;
    logic [2:0] i_addr_strap_high;
    logic [6:0] i_addr, o_eff_addr;
    logic [7:0] i_cmd_code, i_cmd_data, i_pp_page, i_pp_code, o_xfer_code, o_xfer_data, o_rd_data;
    logic [7:0] o_channel_select, o_write_lock_level;
    logic o_addr_ack, o_addr_global, o_cmd_ack, o_cmd_nack, o_xfer_valid, o_xfer_write;
    logic o_xfer_own, o_cml_data_fault, o_cml_comm_fault, a, g;
    logic [1:0] o_addr_rail_mask, o_xfer_ch_mask, m;
    int n_errors = 0;
    int comparisons = 0;
    pmwp_top pmwp_top_inst (.*);
    pmwp_host pmwp_host_inst (.i_clk(i_clk), .i_cmd_ack(o_cmd_ack), .i_addr_ack(o_addr_ack),
        .i_addr_global(o_addr_global), .i_rail_mask(o_addr_rail_mask), .o_cmd_valid(i_cmd_valid),
        .o_cmd_write(i_cmd_write), .o_cmd_w1c(i_cmd_w1c), .o_cmd_paged(i_cmd_paged),
        .o_cmd_code(i_cmd_code), .o_cmd_data(i_cmd_data), .o_pp_page(i_pp_page),
        .o_pp_code(i_pp_code), .o_addr_valid(i_addr_valid), .o_addr(i_addr));
    // Clock
    initial i_clk = 1'b0;
    always #2 i_clk = ~i_clk;
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        if (n_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Expected write permission from level and pin
    function automatic logic allowed(input logic [7:0] lv, input logic pin, input logic [7:0] c);
        if (pin) return c inside {8'h00, 8'h01, 8'hfc, 8'hfe, 8'h03};
        if (lv[7]) return c inside {8'h10, 8'h00, 8'hfe, 8'h15};
        if (lv[6]) return c inside {8'h10, 8'h00, 8'hfe, 8'h15, 8'hfc, 8'h01, 8'h03};
        if (lv[5]) return c inside {8'h10, 8'h00, 8'hfe, 8'h15, 8'hfc, 8'h01, 8'h03, 8'h02, 8'h21};
        return 1'b1;
    endfunction
    // Reset values of the own registers
    task automatic sc_reset_values;
        logic [7:0] cd [4] = '{8'h00, 8'h10, 8'he6, 8'hfa};
        logic [7:0] rv [4] = '{8'h00, 8'h00, 8'h4f, 8'h80};
        for (int k = 0; k < 4; k++) begin
            pmwp_host_inst.cmd(0, 0, cd[k], 8'h00, 0, 8'h00, 8'h00, a);
            check(o_rd_data, rv[k]);
        end
    endtask
    // Page steering and combined packets
    task automatic sc_paging;
        logic [7:0] pg [3] = '{8'h01, 8'h00, 8'hff};
        logic [1:0] mk [3] = '{2'h2, 2'h1, 2'h3};
        for (int k = 0; k < 3; k++) begin
            pmwp_host_inst.cmd(1, 0, 8'h00, pg[k], 0, 8'h00, 8'h00, a);
            pmwp_host_inst.cmd(1, 0, 8'h21, 8'h5c, 1, 8'h00, 8'h00, a);
            check(o_xfer_ch_mask, mk[k]);
        end
        pmwp_host_inst.cmd(0, 0, 8'h21, 8'h00, 1, 8'h00, 8'h00, a);
        check(o_xfer_ch_mask, 2'h1);
        pmwp_host_inst.cmd(1, 0, 8'hfa, 8'h33, 0, 8'h00, 8'h00, a);
        pmwp_host_inst.cmd(1, 0, 8'h05, 8'h44, 0, 8'h00, 8'hfa, a);
        pmwp_host_inst.cmd(0, 0, 8'h06, 8'h00, 0, 8'h01, 8'hfa, a);
        check(o_rd_data, 8'h33);
        check({o_xfer_valid, o_xfer_write, o_xfer_own}, 3'h5);
        pmwp_host_inst.cmd(0, 0, 8'hfa, 8'h00, 0, 8'h00, 8'h00, a);
        check(o_rd_data, 8'h44);
        check(o_channel_select, 8'hff);
        pmwp_host_inst.cmd(1, 0, 8'h05, 8'h01, 0, 8'h00, 8'h00, a);
        check(o_channel_select, 8'hff);
        pmwp_host_inst.cmd(0, 0, 8'h06, 8'h00, 1, 8'hff, 8'h21, a);
        check(o_xfer_ch_mask, 2'h1);
        pmwp_host_inst.cmd(1, 0, 8'h05, 8'h12, 0, 8'h07, 8'h21, a);
        check(o_xfer_ch_mask, 2'h0);
        check({o_xfer_valid, o_xfer_write, o_xfer_own}, 3'h6);
        check(o_xfer_code, 8'h21);
        check(o_xfer_data, 8'h12);
        pmwp_host_inst.cmd(1, 0, 8'h05, 8'h00, 0, 8'h00, 8'h06, a);
        check(a, 1'b0);
        check(o_cml_data_fault, 1'b1);
        pmwp_host_inst.cmd(1, 0, 8'h00, 8'h00, 0, 8'h00, 8'h00, a);
    endtask
    // Write permission per lock level, then under the pin
    task automatic sc_protect;
        logic [7:0] lv [5] = '{8'h80, 8'h40, 8'h20, 8'h00, 8'h00};
        logic [7:0] cd [10] = '{8'h10, 8'h00, 8'hfe, 8'h15, 8'hfc, 8'h01, 8'h03, 8'h02, 8'h21,
                                8'he6};
        logic [7:0] d;
        for (int k = 0; k < 5; k++) begin
            pmwp_host_inst.cmd(1, 0, 8'h10, lv[k], 0, 8'h00, 8'h00, a);
            i_wp_pin = (k == 4);
            repeat (3) @(posedge i_clk);
            #1;
            check(o_write_lock_level, lv[k]);
            for (int j = 0; j < 10; j++) begin
                d = (j == 0) ? lv[k] : ((j == 9) ? 8'h4f : 8'h00);
                pmwp_host_inst.cmd(1, 0, cd[j], d, 0, 8'h00, 8'h00, a);
                check(a, allowed(lv[k], k == 4, cd[j]));
            end
            pmwp_host_inst.cmd(1, 0, 8'h05, 8'h00, 0, 8'h00, 8'h21, a);
            check(a, allowed(lv[k], k == 4, 8'h21));
            pmwp_host_inst.cmd(1, 1, 8'h7a, 8'h01, 0, 8'h00, 8'h00, a);
            check(a, k > 0);
            if (k == 0) begin
                pmwp_host_inst.cmd(1, 0, 8'he6, 8'h11, 0, 8'h00, 8'h00, a);
                pmwp_host_inst.cmd(0, 0, 8'he6, 8'h00, 0, 8'h00, 8'h00, a);
                check(o_rd_data, 8'h4f);
            end
        end
        i_wp_pin = 1'b0;
    endtask
    // Straps, device, global and rail addresses
    task automatic sc_address;
        check(o_eff_addr, 7'h23);
        pmwp_host_inst.probe(7'h23, a, g, m);
        check(a, 1'b1);
        i_addr_strap_high_open = 1'b1;
        repeat (3) @(posedge i_clk);
        #1;
        check(o_eff_addr, 7'h43);
        i_addr_strap_low_open = 1'b1;
        repeat (3) @(posedge i_clk);
        #1;
        check(o_eff_addr, 7'h4f);
        pmwp_host_inst.cmd(1, 0, 8'he6, 8'h80, 0, 8'h00, 8'h00, a);
        pmwp_host_inst.probe(7'h00, a, g, m);
        check(a, 1'b0);
        pmwp_host_inst.probe(7'h5b, a, g, m);
        check({a, g}, 2'h3);
        pmwp_host_inst.probe(7'h44, a, g, m);
        check(m, 2'h1);
        pmwp_host_inst.cmd(1, 0, 8'h05, 8'h80, 0, 8'h01, 8'hfa, a);
        pmwp_host_inst.probe(7'h00, a, g, m);
        check(m, 2'h0);
        i_rail_rd_mismatch = 1'b1;
        @(posedge i_clk);
        #1;
        i_rail_rd_mismatch = 1'b0;
        check(o_cml_comm_fault, 1'b1);
    endtask
    // Watchdog on the whole run
    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        summarize();
    end
    // Main sequence
    initial begin
        {i_reset_n, i_clk_en, i_wp_pin, i_rail_rd_mismatch} = 4'h4;
        {i_addr_strap_low_open, i_addr_strap_high_open} = 2'h0;
        {i_addr_strap_high, i_addr_strap_low} = 7'h23;
        repeat (3) @(posedge i_clk);
        #1;
        i_reset_n = 1'b1;
        sc_reset_values();
        sc_paging();
        sc_protect();
        sc_address();
        summarize();
    end
endmodule
bind pmwp_top pmwp_chk pmwp_chk_inst (.*);
